// >>> ctp_pin_model.sv
// External pin model: free-running slow oscillator and event pulse source
`default_nettype none
module ctp_pin_model (
  input wire logic i_core_clk,
  output logic o_slow_clk,
  output logic o_event_in_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Oscillator runs free; 64 core cycles a period keeps the divider exact
  initial begin
    o_slow_clk = 1'b0;
    #1.3;
    forever #160 o_slow_clk = ~o_slow_clk;
  end
  // Pulled up when idle, so only commanded pulses give falling edges
  initial o_event_in_pin = 1'b1;
  // Each phase spans 8 core cycles: the fastest input allowed
  task automatic send_falls(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_event_in_pin <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      o_event_in_pin <= 1'b1;
      repeat (7) @(posedge i_core_clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> ctp_pkg.sv
// Constants and types for the cascaded 16-bit timer pair
`default_nettype none
package ctp_pkg;
  localparam int CTP_NPAIR = 2;
  // Register byte offsets within a pair, pair B one stride higher
  localparam logic [7:0] CTP_PAIR_STRIDE = 8'h20;
  localparam logic [7:0] CTP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CTP_OFF_CMP_LO = 8'h04;
  localparam logic [7:0] CTP_OFF_CMP_HI = 8'h08;
  localparam logic [7:0] CTP_OFF_DUTY_LO = 8'h0c;
  localparam logic [7:0] CTP_OFF_DUTY_HI = 8'h10;
  localparam logic [7:0] CTP_OFF_COUNT = 8'h14;
  localparam logic [7:0] CTP_OFF_STAT = 8'h18;
  localparam logic [7:0] CTP_OFF_GLOBAL = 8'h40;
  // Field positions
  localparam int CTP_GLB_PRESEL_BIT = 0;
  localparam int CTP_GLB_SLOW_BIT = 1;
  localparam int CTP_STAT_FF_BIT = 0;
  localparam int CTP_STAT_HALF_BIT = 1;
  // Reset values
  localparam logic [7:0] CTP_CTRL_RST = 8'h00;
  localparam logic [15:0] CTP_WORD_RST = 16'h0000;
  localparam logic [7:0] CTP_BYTE_RST = 8'h00;
  localparam logic [1:0] CTP_GLB_RST = 2'h0;
  localparam logic [15:0] CTP_CNT_MAX = 16'hffff;
  // Prescaler exponents
  localparam int CTP_EXP_A = 11;
  localparam int CTP_EXP_B = 7;
  localparam int CTP_EXP_C = 5;
  localparam int CTP_EXP_D = 3;
  localparam int CTP_SLOW_EXP = 3;
  typedef enum logic [1:0] {
    CTP_M_TIMER, CTP_M_EVENT, CTP_M_PWM, CTP_M_PPG
  } ctp_mode_t;
  typedef enum logic [2:0] {
    CTP_SRC_DIV_A, CTP_SRC_DIV_B, CTP_SRC_DIV_C, CTP_SRC_DIV_D,
    CTP_SRC_SLOW, CTP_SRC_HALF, CTP_SRC_FAST, CTP_SRC_NONE
  } ctp_src_t;
  // Control register layout, mode in the low bits
  typedef struct packed {
    logic ff_init;
    logic latch;
    logic run;
    ctp_src_t src;
    ctp_mode_t mode;
  } ctp_ctrl_t;
  // One-cycle count enables from the prescaler and the pins
  typedef struct packed {
    logic evt_fall;
    logic slow8;
    logic slow;
    logic fast;
    logic half;
    logic div_d;
    logic div_c;
    logic div_b;
    logic div_a;
  } ctp_tick_t;
endpackage
`default_nettype wire

// >>> ctp_tick_gen.sv
// Prescaler and pin synchronisers feeding count enables
`default_nettype none
module ctp_tick_gen (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_slow_clk,
  input wire logic i_event_in_pin,
  output var ctp_pkg::ctp_tick_t o_tick
);
  logic [ctp_pkg::CTP_EXP_A-1:0] div_r;
  logic [ctp_pkg::CTP_SLOW_EXP-1:0] slow_div_r;
  logic [2:0] slow_sync_r;
  logic [2:0] evt_sync_r;
  logic slow_lvl_r;
  logic evt_lvl_r;
  logic slow_rise;
  logic evt_fall;
  ctp_pkg::ctp_tick_t tick_nxt;

  // Free-running fast divider
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Three-stage synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_sync_r <= 3'h0;
      evt_sync_r <= 3'h0;
    end else begin
      slow_sync_r <= {slow_sync_r[1:0], i_slow_clk};
      evt_sync_r <= {evt_sync_r[1:0], i_event_in_pin};
    end
  end

  // Filtered levels: accept a change once stages 1 and 2 agree
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_lvl_r <= 1'b0;
      evt_lvl_r <= 1'b0;
    end else begin
      if (slow_sync_r[2] == slow_sync_r[1]) slow_lvl_r <= slow_sync_r[2];
      if (evt_sync_r[2] == evt_sync_r[1]) evt_lvl_r <= evt_sync_r[2];
    end
  end

  // Slow clock divided by eight
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_div_r <= '0;
    end else if (slow_rise) begin
      slow_div_r <= slow_div_r + 1'b1;
    end
  end

  // Enables decoded from divider and filtered pins
  always_comb begin
    slow_rise = (slow_sync_r[2] == slow_sync_r[1]) & slow_sync_r[2] & ~slow_lvl_r;
    evt_fall = (evt_sync_r[2] == evt_sync_r[1]) & ~evt_sync_r[2] & evt_lvl_r;
    tick_nxt.div_a = &div_r[ctp_pkg::CTP_EXP_A-1:0];
    tick_nxt.div_b = &div_r[ctp_pkg::CTP_EXP_B-1:0];
    tick_nxt.div_c = &div_r[ctp_pkg::CTP_EXP_C-1:0];
    tick_nxt.div_d = &div_r[ctp_pkg::CTP_EXP_D-1:0];
    tick_nxt.half = div_r[0];
    tick_nxt.fast = 1'b1;
    tick_nxt.slow = slow_rise;
    tick_nxt.slow8 = slow_rise & (&slow_div_r);
    tick_nxt.evt_fall = evt_fall;
  end

  // Registered to keep the pair logic off the decode path
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick <= '0;
    end else begin
      o_tick <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> ctp_timer_pair.sv
// Two cascaded 16-bit timer pairs behind an Avalon-MM slave
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`default_nettype none
module ctp_timer_pair (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_slow_clk,
  input wire logic i_event_in_pin,
  output logic o_pwm_out_a,
  output logic o_pwm_out_b,
  output logic o_ppg_out_a,
  output logic o_ppg_out_b,
  output logic o_pair_a_irq,
  output logic o_pair_b_irq
);
  ctp_pkg::ctp_tick_t tick_w;
  logic wait_r;
  logic wr_go;
  logic wr_glb;
  logic [1:0] glb_r;
  logic [31:0] rd_nxt;
  logic [7:0] reg_off;
  logic sel_b;
  logic [ctp_pkg::CTP_NPAIR-1:0][7:0] ctrl_v;
  logic [ctp_pkg::CTP_NPAIR-1:0][15:0] cmp_v;
  logic [ctp_pkg::CTP_NPAIR-1:0][15:0] duty_v;
  logic [ctp_pkg::CTP_NPAIR-1:0][15:0] cnt_v;
  logic [ctp_pkg::CTP_NPAIR-1:0][1:0] stat_v;
  logic [ctp_pkg::CTP_NPAIR-1:0] pwm_v;
  logic [ctp_pkg::CTP_NPAIR-1:0] ppg_v;
  logic [ctp_pkg::CTP_NPAIR-1:0] irq_v;

  // Register address of a pair's register
  function automatic logic reg_hit(input logic [7:0] a, input logic pb,
                                   input logic [7:0] off);
    logic [7:0] base;
    base = pb ? ctp_pkg::CTP_PAIR_STRIDE : 8'h00;
    reg_hit = (a == base + off);
  endfunction

  // Cascade increment: low byte carry steps the high byte
  function automatic logic [15:0] cas_inc(input logic [7:0] lo, input logic [7:0] hi);
    logic [8:0] lo_sum;
    lo_sum = {1'b0, lo} + 9'h001;
    cas_inc = {hi + {7'h00, lo_sum[8]}, lo_sum[7:0]};
  endfunction

  // Count enable for a pair from its mode and source
  function automatic logic pick_tick(input ctp_pkg::ctp_tick_t t,
                                     input ctp_pkg::ctp_ctrl_t c,
                                     input logic presel, input logic slow,
                                     input logic pb);
    logic pwm;
    pwm = (c.mode == ctp_pkg::CTP_M_PWM);
    pick_tick = 1'b0;
    if (c.mode == ctp_pkg::CTP_M_EVENT) begin
      pick_tick = t.evt_fall & ~pb;
    end else begin
      case (c.src)
        ctp_pkg::CTP_SRC_DIV_A: pick_tick = (presel | slow) ? t.slow8 : t.div_a;
        ctp_pkg::CTP_SRC_DIV_B: pick_tick = ~slow & t.div_b;
        ctp_pkg::CTP_SRC_DIV_C: pick_tick = ~slow & t.div_c;
        ctp_pkg::CTP_SRC_DIV_D: pick_tick = ~slow & t.div_d;
        ctp_pkg::CTP_SRC_SLOW: pick_tick = pwm & t.slow;
        ctp_pkg::CTP_SRC_HALF: pick_tick = pwm & ~slow & t.half;
        ctp_pkg::CTP_SRC_FAST: pick_tick = pwm & ~slow & t.fast;
        default: pick_tick = 1'b0;
      endcase
    end
  endfunction

  ctp_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_slow_clk(i_slow_clk),
    .i_event_in_pin(i_event_in_pin),
    .o_tick(tick_w)
  );

  // One wait state: request seen, answer next cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((i_read | i_write) & wait_r);
    end
  end

  assign o_waitrequest = wait_r;
  // Writes land on the edge that completes the transfer; lane 0 only
  assign wr_go = i_write & ~wait_r & i_byteenable[0];
  assign wr_glb = wr_go & (i_address == ctp_pkg::CTP_OFF_GLOBAL);
  assign reg_off = {3'b000, i_address[4:0]};
  assign sel_b = i_address[5];

  // Global mode bits: slow-clock prescaler choice and slow system mode
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      glb_r <= ctp_pkg::CTP_GLB_RST;
    end else if (wr_glb) begin
      glb_r <= i_writedata[1:0];
    end
  end

  // Read mux; unmapped and misaligned addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (i_address == ctp_pkg::CTP_OFF_GLOBAL) begin
      rd_nxt = {30'h0, glb_r};
    end else if (i_address[7:6] != 2'b00) begin
      rd_nxt = 32'h0000_0000;
    end else if (reg_off == ctp_pkg::CTP_OFF_CTRL) begin
      rd_nxt = {24'h0, ctrl_v[sel_b]};
    end else if (reg_off == ctp_pkg::CTP_OFF_CMP_LO) begin
      rd_nxt = {24'h0, cmp_v[sel_b][7:0]};
    end else if (reg_off == ctp_pkg::CTP_OFF_CMP_HI) begin
      rd_nxt = {24'h0, cmp_v[sel_b][15:8]};
    end else if (reg_off == ctp_pkg::CTP_OFF_DUTY_LO) begin
      rd_nxt = {24'h0, duty_v[sel_b][7:0]};
    end else if (reg_off == ctp_pkg::CTP_OFF_DUTY_HI) begin
      rd_nxt = {24'h0, duty_v[sel_b][15:8]};
    end else if (reg_off == ctp_pkg::CTP_OFF_COUNT) begin
      rd_nxt = {16'h0, cnt_v[sel_b]};
    end else if (reg_off == ctp_pkg::CTP_OFF_STAT) begin
      rd_nxt = {30'h0, stat_v[sel_b]};
    end
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read & wait_r) begin
      o_readdata <= rd_nxt;
    end
  end

  for (genvar gp = 0; gp < ctp_pkg::CTP_NPAIR; gp++) begin : g_pair
    localparam logic IS_B = 1'(gp);
    ctp_pkg::ctp_ctrl_t ctrl_r;
    ctp_pkg::ctp_ctrl_t ctrl_in;
    logic [15:0] cmp_r;
    logic [15:0] duty_act_r;
    logic [15:0] duty_buf_r;
    logic [15:0] cnt_now;
    logic [15:0] cnt_inc;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] dlo_pend_r;
    logic half_r;
    logic ff_r;
    logic irq_r;
    logic pwm_pin_r;
    logic ppg_pin_r;
    logic tick;
    logic step;
    logic ovf;
    logic cmp_hit;
    logic duty_hit;
    logic clr;
    logic tgl;
    logic is_pwm;
    logic is_ppg;
    logic commit;
    logic wr_ctrl;
    logic wr_clo;
    logic wr_chi;
    logic wr_dlo;
    logic wr_dhi;

    assign wr_ctrl = wr_go & reg_hit(i_address, IS_B, ctp_pkg::CTP_OFF_CTRL);
    assign wr_clo = wr_go & reg_hit(i_address, IS_B, ctp_pkg::CTP_OFF_CMP_LO);
    assign wr_chi = wr_go & reg_hit(i_address, IS_B, ctp_pkg::CTP_OFF_CMP_HI);
    assign wr_dlo = wr_go & reg_hit(i_address, IS_B, ctp_pkg::CTP_OFF_DUTY_LO);
    assign wr_dhi = wr_go & reg_hit(i_address, IS_B, ctp_pkg::CTP_OFF_DUTY_HI);

    // Match, overflow and toggle decisions for this pair
    always_comb begin
      cnt_now = {cnt_hi_r, cnt_lo_r};
      cnt_inc = cas_inc(cnt_lo_r, cnt_hi_r);
      is_pwm = (ctrl_r.mode == ctp_pkg::CTP_M_PWM);
      is_ppg = (ctrl_r.mode == ctp_pkg::CTP_M_PPG);
      tick = pick_tick(tick_w, ctrl_r, glb_r[ctp_pkg::CTP_GLB_PRESEL_BIT],
                       glb_r[ctp_pkg::CTP_GLB_SLOW_BIT], IS_B);
      step = tick & ctrl_r.run;
      ovf = (cnt_now == ctp_pkg::CTP_CNT_MAX);
      cmp_hit = (cnt_inc == cmp_r);
      duty_hit = (cnt_inc == duty_act_r);
      if (is_pwm) begin
        clr = step & ovf;
        tgl = duty_hit ^ ovf;
      end else if (is_ppg) begin
        clr = step & cmp_hit;
        tgl = duty_hit ^ cmp_hit;
      end else begin
        clr = step & cmp_hit;
        tgl = 1'b0;
      end
      ctrl_in = ctp_pkg::ctp_ctrl_t'(i_writedata[7:0]);
      // Pair B refuses the event mode and keeps its old mode
      if (IS_B && (ctrl_in.mode == ctp_pkg::CTP_M_EVENT)) begin
        ctrl_in.mode = ctrl_r.mode;
      end
      commit = wr_dhi & half_r;
    end

    // Control register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ctrl_r <= ctp_pkg::ctp_ctrl_t'(ctp_pkg::CTP_CTRL_RST);
      end else if (wr_ctrl) begin
        ctrl_r <= ctrl_in;
      end
    end

    // Compare/period bytes are single-stage: used the cycle after the write
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cmp_r <= ctp_pkg::CTP_WORD_RST;
      end else if (wr_clo) begin
        cmp_r[7:0] <= i_writedata[7:0];
      end else if (wr_chi) begin
        cmp_r[15:8] <= i_writedata[7:0];
      end
    end

    // Duty low half waits for its high half
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        dlo_pend_r <= ctp_pkg::CTP_BYTE_RST;
        half_r <= 1'b0;
      end else if (wr_dlo) begin
        dlo_pend_r <= i_writedata[7:0];
        half_r <= 1'b1;
      end else if (wr_dhi) begin
        half_r <= 1'b0;
      end
    end

    // Duty buffer stage, filled by a complete low-then-high pair
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        duty_buf_r <= ctp_pkg::CTP_WORD_RST;
      end else if (commit) begin
        duty_buf_r <= {i_writedata[7:0], dlo_pend_r};
      end
    end

    // Active duty: direct when stopped or not PWM, else at overflow
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        duty_act_r <= ctp_pkg::CTP_WORD_RST;
      end else if (commit && (!ctrl_r.run || !is_pwm)) begin
        duty_act_r <= {i_writedata[7:0], dlo_pend_r};
      end else if (clr && is_pwm) begin
        duty_act_r <= duty_buf_r;
      end
    end

    // Cascaded up-counter; held at zero while stopped
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cnt_lo_r <= ctp_pkg::CTP_BYTE_RST;
        cnt_hi_r <= ctp_pkg::CTP_BYTE_RST;
      end else if (!ctrl_r.run) begin
        cnt_lo_r <= ctp_pkg::CTP_BYTE_RST;
        cnt_hi_r <= ctp_pkg::CTP_BYTE_RST;
      end else if (clr) begin
        cnt_lo_r <= ctp_pkg::CTP_BYTE_RST;
        cnt_hi_r <= ctp_pkg::CTP_BYTE_RST;
      end else if (step) begin
        cnt_lo_r <= cnt_inc[7:0];
        cnt_hi_r <= cnt_inc[15:8];
      end
    end

    // Output flip-flop; the stopping write itself never reloads it
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ff_r <= 1'b0;
      end else if (wr_ctrl && !ctrl_r.run) begin
        ff_r <= ctrl_in.ff_init;
      end else if (step && tgl) begin
        ff_r <= ~ff_r;
      end
    end

    // Pins: inverted flip-flop gated by the port latch, PPG pin in PPG mode, PWM pin otherwise; the other pin shows the latch
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pwm_pin_r <= 1'b0;
        ppg_pin_r <= 1'b0;
      end else begin
        pwm_pin_r <= ctrl_r.latch & (is_ppg | ~ff_r);
        ppg_pin_r <= ctrl_r.latch & (~is_ppg | ~ff_r);
      end
    end

    // Interrupt pulse on every clearing match or overflow
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        irq_r <= 1'b0;
      end else begin
        irq_r <= clr;
      end
    end

    assign ctrl_v[gp] = ctrl_r;
    assign cmp_v[gp] = cmp_r;
    assign duty_v[gp] = duty_act_r;
    assign cnt_v[gp] = cnt_now;
    assign stat_v[gp][ctp_pkg::CTP_STAT_FF_BIT] = ff_r;
    assign stat_v[gp][ctp_pkg::CTP_STAT_HALF_BIT] = half_r;
    assign pwm_v[gp] = pwm_pin_r;
    assign ppg_v[gp] = ppg_pin_r;
    assign irq_v[gp] = irq_r;
  end

  // Top outputs are the pair pin and interrupt registers
  assign o_pwm_out_a = pwm_v[0];
  assign o_pwm_out_b = pwm_v[1];
  assign o_ppg_out_a = ppg_v[0];
  assign o_ppg_out_b = ppg_v[1];
  assign o_pair_a_irq = irq_v[0];
  assign o_pair_b_irq = irq_v[1];
endmodule
`default_nettype wire

// >>> ctp_timer_pair_props.sv
// Checker for bus handshake, interrupt pulses and reset state of the timer pair
`default_nettype none
module ctp_timer_pair_props (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_pwm_out_a,
  input wire logic o_pwm_out_b,
  input wire logic o_ppg_out_a,
  input wire logic o_ppg_out_b,
  input wire logic o_pair_a_irq,
  input wire logic o_pair_b_irq
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Interrupts are single-cycle pulses
  a_irq_a_pulse: assert property (o_pair_a_irq |=> !o_pair_a_irq)
    else $error("irq a too long");
  a_irq_b_pulse: assert property (o_pair_b_irq |=> !o_pair_b_irq)
    else $error("irq b too long");
  // One wait state, then exactly one answer cycle
  a_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered");
  a_bus_one_low: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low twice");
  a_bus_idle: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("waitrequest dropped while idle");
  a_low_has_req: assert property (!o_waitrequest |-> $past(i_read || i_write))
    else $error("answer without request");
  // First edge after reset must still show the cleared state
  a_reset_pins: assert property ($rose(i_rst_n) |->
    !(o_pwm_out_a || o_pwm_out_b || o_ppg_out_a || o_ppg_out_b))
    else $error("pins not cleared by reset");
  a_reset_irq: assert property ($rose(i_rst_n) |->
    !o_pair_a_irq && !o_pair_b_irq && o_waitrequest && o_readdata == 32'h0)
    else $error("bus or irq not cleared by reset");
  c_irq_a: cover property (o_pair_a_irq);
  c_irq_b: cover property (o_pair_b_irq);
  c_write: cover property (i_write && !o_waitrequest);
endmodule
bind ctp_timer_pair ctp_timer_pair_props u_props (
  .i_core_clk, .i_rst_n, .i_read, .i_write, .o_readdata, .o_waitrequest,
  .o_pwm_out_a, .o_pwm_out_b, .o_ppg_out_a, .o_ppg_out_b, .o_pair_a_irq, .o_pair_b_irq
);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the cascaded timer pair
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [1:0] glb; logic [2:0] src; int gap;} ctp_row_t;
  // Timer sources with compare 1: irq gap equals the divider; 0 means no ticks
  // Last two rows: PWM-only sources must stay silent in timer mode
  ctp_row_t rows [9] = '{'{2'h0, 3'h0, 2048}, '{2'h0, 3'h1, 128}, '{2'h0, 3'h2, 32},
    '{2'h0, 3'h3, 8}, '{2'h1, 3'h0, 512}, '{2'h2, 3'h0, 512}, '{2'h2, 3'h3, 0},
    '{2'h0, 3'h4, 0}, '{2'h0, 3'h6, 0}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, slow_clk, event_pin, pwm_a, pwm_b, ppg_a, ppg_b, irq_a, irq_b, f, p;
  int fails = 0;
  int total_checks = 0;
  int n, m, k, j;
  always #2.5 clk = ~clk;
  ctp_timer_pair u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_address(address),
    .i_read(read), .i_write(write), .i_writedata(writedata), .i_byteenable(byteenable),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .i_slow_clk(slow_clk),
    .i_event_in_pin(event_pin), .o_pwm_out_a(pwm_a), .o_pwm_out_b(pwm_b),
    .o_ppg_out_a(ppg_a), .o_ppg_out_b(ppg_b), .o_pair_a_irq(irq_a), .o_pair_b_irq(irq_b));
  ctp_pin_model u_pins (.i_core_clk(clk), .o_slow_clk(slow_clk), .o_event_in_pin(event_pin));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    byteenable <= 4'h1;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (t >= 50) fails++;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(what, exp, rd);
  endtask
  // Control byte; port latch always set so the pins show the flip-flop
  function automatic logic [7:0] ctl(input logic ff, input logic run, input logic [2:0] src,
                                     input logic [1:0] md);
    ctp_pkg::ctp_ctrl_t c;
    c = '{ff, 1'b1, run, ctp_pkg::ctp_src_t'(src), ctp_pkg::ctp_mode_t'(md)};
    return c;
  endfunction
  // Cycles until the chosen irq is seen, or the limit
  task automatic wait_irq(input logic b, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while ((b ? irq_b : irq_a) !== 1'b1 && c < lim);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog sized from the longest case, one full 16-bit PWM period
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    results;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wr8(8'h04, 8'h01);
    wr8(8'h08, 8'h00);
    foreach (rows[i]) begin
      wr8(8'h40, {6'h0, rows[i].glb});
      wr8(8'h00, ctl(1'b0, 1'b1, rows[i].src, 2'h0));
      if (rows[i].gap == 0) begin
        wait_irq(1'b0, 700, n);
        chk("no tick", 700, n);
      end else begin
        wait_irq(1'b0, 2 * rows[i].gap + 60, n);
        wait_irq(1'b0, rows[i].gap + 60, m);
        chk("irq gap", rows[i].gap, m);
      end
      wr8(8'h00, ctl(1'b0, 1'b0, rows[i].src, 2'h0));
    end
    wr8(8'h40, 8'h00);
    $display("done: timer sources");
    // Event counting on pair A with compare 3
    wr8(8'h04, 8'h03);
    wr8(8'h08, 8'h00);
    wr8(8'h00, ctl(1'b0, 1'b1, 3'h7, 2'h1));
    u_pins.send_falls(2);
    rchk("event count", 8'h14, 32'h2);
    fork
      u_pins.send_falls(1);
      wait_irq(1'b0, 40, n);
    join
    chk("event irq", 1, n < 40);
    rchk("event clear", 8'h14, 32'h0);
    u_pins.send_falls(1);
    rchk("event resume", 8'h14, 32'h1);
    wr8(8'h00, ctl(1'b0, 1'b0, 3'h7, 2'h1));
    // Pair B refuses the event mode but takes the other fields
    wr8(8'h20, ctl(1'b0, 1'b0, 3'h3, 2'h1));
    rchk("b mode", 8'h20, {24'h0, ctl(1'b0, 1'b0, 3'h3, 2'h0)});
    $display("done: event");
    // PPG on pair A: duty 4, period 10 ticks of fast/8
    wr8(8'h0c, 8'h04);
    wr8(8'h10, 8'h00);
    wr8(8'h04, 8'h0a);
    wr8(8'h08, 8'h00);
    wr8(8'h00, ctl(1'b1, 1'b0, 3'h3, 2'h3));
    rchk("ppg ff init", 8'h18, 32'h1);
    chk("ppg pin init", 1'b0, ppg_a);
    wr8(8'h00, ctl(1'b1, 1'b1, 3'h3, 2'h3));
    wait_irq(1'b0, 200, n);
    wait_irq(1'b0, 200, m);
    chk("ppg period", 80, m);
    k = 0;
    repeat (80) begin
      @(posedge clk);
      k += (ppg_a === 1'b1);
    end
    chk("ppg high", 48, k);
    // Stop holds the level; init bit then forces the other one
    wr8(8'h00, ctl(1'b1, 1'b0, 3'h3, 2'h3));
    xfer(1'b0, 8'h18, 8'h00);
    f = rd[0];
    p = ppg_a;
    repeat (20) @(posedge clk);
    chk("ppg held", p, ppg_a);
    wr8(8'h00, ctl(~f, 1'b0, 3'h3, 2'h3));
    repeat (3) @(posedge clk);
    chk("ppg forced", f, ppg_a);
    $display("done: ppg");
    // Reset in mid-run with the flip-flop set
    wr8(8'h00, ctl(1'b1, 1'b1, 3'h3, 2'h3));
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("stat reset", 8'h18, 32'h0);
    rchk("ctrl reset", 8'h00, {24'h0, ctp_pkg::CTP_CTRL_RST});
    rchk("count reset", 8'h14, 32'h0);
    rchk("unmapped", 8'h3c, 32'h0);
    chk("ppg pin reset", 1'b0, ppg_a);
    $display("done: reset");
    // PWM on both pairs at the fast clock; lone halves first
    wr8(8'h00, ctl(1'b0, 1'b0, 3'h6, 2'h2));
    wr8(8'h20, ctl(1'b0, 1'b0, 3'h6, 2'h2));
    wr8(8'h10, 8'h55);
    rchk("lone upper", 8'h10, 32'h0);
    wr8(8'h0c, 8'h00);
    rchk("half pending", 8'h18, 32'h2);
    wr8(8'h10, 8'h80);
    rchk("duty stopped", 8'h10, 32'h80);
    wr8(8'h2c, 8'h00);
    wr8(8'h30, 8'h10);
    wr8(8'h00, ctl(1'b0, 1'b1, 3'h6, 2'h2));
    wr8(8'h20, ctl(1'b0, 1'b1, 3'h6, 2'h2));
    wr8(8'h0c, 8'h00);
    wr8(8'h10, 8'h01);
    rchk("duty held", 8'h10, 32'h80);
    fork
      begin
        wait_irq(1'b0, 70000, n);
        // Pin register lags the irq pulse by one cycle
        @(posedge clk);
        k = 0;
        while (pwm_a === 1'b1 && k < 400) begin
          @(posedge clk);
          k++;
        end
      end
      begin
        wait_irq(1'b1, 70000, m);
        @(posedge clk);
        j = 0;
        while (pwm_b === 1'b1 && j < 5000) begin
          @(posedge clk);
          j++;
        end
      end
    join
    chk("pwm a high", 256, k);
    chk("pwm b high", 4096, j);
    rchk("duty moved", 8'h10, 32'h01);
    chk("ppg b latch", 1'b1, ppg_b);
    // Both timers stopped before the results
    wr8(8'h00, ctl(1'b0, 1'b0, 3'h6, 2'h2));
    wr8(8'h20, ctl(1'b0, 1'b0, 3'h6, 2'h2));
    $display("done: pwm");
    results;
  end
endmodule
`default_nettype wire
